// >>> ldms_consts.svh
`ifndef LDMS_CONSTS_SVH
`define LDMS_CONSTS_SVH

// ************************************************************
// Clock and timing
// ************************************************************
`define LDMS_CLK_NS 100
`define LDMS_SOFT_MS 100
`define LDMS_SHORT_NS 6500
`define LDMS_STAGGER_NS 100
`define LDMS_DETECT_CYC 16

// ************************************************************
// Dimming pulse thresholds in switching clocks
// ************************************************************
`define LDMS_SHORT_PULSE_CLKS 5
`define LDMS_RESUME_CLKS 6
`define LDMS_ON_CNT_MAX 7

// ************************************************************
// Sizes and reset values
// ************************************************************
`define LDMS_CHANNELS 4
`define LDMS_UNUSED_RST 4'h0

`endif

// >>> ldms_ext_ctrl.sv
`timescale 1ns/10ps

// ************************************************************
// External controller and switching oscillator
// ************************************************************
module ldms_ext_ctrl #(
  parameter int OSC_HALF = 4
) (
  input wire logic sys_clk,
  input wire logic enReq,
  input wire logic dimLevel,
  input wire logic [3:0] pulseCount,
  input wire logic pulseStart,
  output logic chipEnable,
  output logic dimming_pwm_input,
  output logic switchOscClock,
  output logic pulseBusy
);
  int oscCnt;
  logic [3:0] left;

  initial begin
    oscCnt = 0;
    chipEnable = 1'b0;
    switchOscClock = 1'b0;
    left = 4'h0;
    pulseBusy = 1'b0;
  end

  // The oscillator runs free, as the real one does, so edges of the
  // enable and dimming pins land at any phase of it.
  always @(negedge sys_clk) begin
    chipEnable <= enReq;
    if (oscCnt == OSC_HALF - 1) begin
      oscCnt <= 0;
      switchOscClock <= ~switchOscClock;
      // Pulses start and stop at oscillator falls so they span whole periods.
      if (switchOscClock && pulseBusy) begin
        left <= left - 4'h1;
        pulseBusy <= (left != 4'h1);
      end else if (switchOscClock && pulseStart) begin
        left <= pulseCount;
        pulseBusy <= 1'b1;
      end
    end else begin
      oscCnt <= oscCnt + 1;
    end
  end

  assign dimming_pwm_input = dimLevel | pulseBusy;
endmodule : ldms_ext_ctrl

// >>> ldms_mode_sequencer.sv
`timescale 1ns/10ps
`include "ldms_consts.svh"

// What this block does
// [RULE_01] Enable low holds shutdown, all halted.
// [RULE_02] Enable and dimming high run boost, sinks.
// [RULE_03] Enable rise detects unused sinks, disables them.
// [RULE_04] Two or more unused stop staggered turn-on.
// [RULE_05] Soft start regulates overvoltage sense at 95%.
// [RULE_06] Soft start lasts at most 100 ms.
// [RULE_07] Soft start ends at first of three events.
// [RULE_08] Soft start done, dimming low: stand-by one.
// [RULE_09] Short pulses: stand-by two, boost on, sinks off.
// [RULE_10] Long pulses: stand-by three, boost off.
// [RULE_11] Operation regulates lowest active sink pin.
// [RULE_12] Short comparator qualified after 6.5 us.
// [RULE_13] Back to sink regulation needs six clocks.
// [RULE_14] Stagger delays each active channel 100 ns.
// [RULE_15] On-time counted in switching clocks after rise.
module ldms_mode_sequencer
  import ldms_pkg::*;
#(
  parameter int CHANNELS = `LDMS_CHANNELS,
  parameter int SOFT_CYCLES = `LDMS_SOFT_MS * 1000000 / `LDMS_CLK_NS,
  parameter int DETECT_CYCLES = `LDMS_DETECT_CYC,
  parameter int SHORT_CYCLES = (`LDMS_SHORT_NS + `LDMS_CLK_NS - 1) / `LDMS_CLK_NS
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic chipEnable,
  input wire logic dimming_pwm_input,
  input wire logic switchOscClock,
  input wire logic [CHANNELS-1:0] sinkPinGrounded,
  input wire logic boostAtSenseTarget,
  input wire logic minSinkAtTarget,
  input wire logic [CHANNELS-1:0] shortCompRaw,
  output ldms_mode_t operatingMode,
  output logic boostEnable,
  output logic feedbackMinSink,
  output logic [CHANNELS-1:0] channelActive,
  output logic staggerEnable,
  output logic [CHANNELS-1:0] led_sink_channel,
  output logic [CHANNELS-1:0] shortQualified
);

  localparam int SYNC_W = 5 + 2 * CHANNELS;
  localparam int SOFT_W = $clog2(SOFT_CYCLES + 1);
  localparam int DET_W = $clog2(DETECT_CYCLES + 1);
  localparam int SHORT_W = $clog2(SHORT_CYCLES + 1);
  localparam logic [2:0] SHORT_CLKS = 3'(`LDMS_SHORT_PULSE_CLKS);
  localparam logic [2:0] RESUME_CLKS = 3'(`LDMS_RESUME_CLKS);
  localparam logic [2:0] ON_MAX = 3'(`LDMS_ON_CNT_MAX);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Every pin is asynchronous to sys_clk, so all pass two flops.
  logic [SYNC_W-1:0] syncA_r;
  logic [SYNC_W-1:0] syncB_r;
  logic [SYNC_W-1:0] pinVec;
  logic enS;
  logic dimS;
  logic oscS;
  logic senseS;
  logic minS;
  logic [CHANNELS-1:0] groundedS;
  logic [CHANNELS-1:0] shortS;

  assign pinVec = {shortCompRaw, sinkPinGrounded, minSinkAtTarget, boostAtSenseTarget,
                   switchOscClock, dimming_pwm_input, chipEnable};

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA_r <= '0;
      syncB_r <= '0;
    end else begin
      syncA_r <= pinVec;
      syncB_r <= syncA_r;
    end
  end

  assign enS = syncB_r[0];
  assign dimS = syncB_r[1];
  assign oscS = syncB_r[2];
  assign senseS = syncB_r[3];
  assign minS = syncB_r[4];
  assign groundedS = syncB_r[5 +: CHANNELS];
  assign shortS = syncB_r[5 + CHANNELS +: CHANNELS];

  // ************************************************************
  // Dimming on-time measurement
  // ************************************************************
  // The count saturates, since only the 5 and 6 clock thresholds matter.
  logic oscPrev_r;
  logic dimPrev_r;
  logic [2:0] onCount_r;
  logic [2:0] onCount_nxt;
  logic oscTick;
  logic dimRise;
  logic dimFall;

  assign oscTick = oscS && !oscPrev_r;
  assign dimRise = dimS && !dimPrev_r;
  assign dimFall = !dimS && dimPrev_r;

  always_comb begin
    onCount_nxt = onCount_r;
    // [RULE_15] Count switching clocks.
    if (dimRise) begin
      onCount_nxt = 3'h0;
    end else if (dimS && oscTick && onCount_r != ON_MAX) begin
      onCount_nxt = onCount_r + 3'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      oscPrev_r <= 1'b0;
      dimPrev_r <= 1'b0;
      onCount_r <= 3'h0;
    end else begin
      oscPrev_r <= oscS;
      dimPrev_r <= dimS;
      onCount_r <= onCount_nxt;
    end
  end

  // ************************************************************
  // Mode state machine
  // ************************************************************
  ldms_mode_t state_r;
  ldms_mode_t state_nxt;
  logic [SOFT_W-1:0] softCnt_r;
  logic [SOFT_W-1:0] softCnt_nxt;
  logic [DET_W-1:0] detCnt_r;
  logic [DET_W-1:0] detCnt_nxt;
  logic [CHANNELS-1:0] unused_r;
  logic [CHANNELS-1:0] unused_nxt;
  logic fbMin_r;
  logic fbMin_nxt;
  logic pulseSeen_r;
  logic pulseSeen_nxt;
  logic running;
  logic softDone;

  assign running = (state_r == LDMS_STANDBY1) || (state_r == LDMS_STANDBY2) ||
                   (state_r == LDMS_STANDBY3) || (state_r == LDMS_OPERATE);
  // [RULE_07] Three soft start exits.
  assign softDone = senseS || (dimS && minS) || (softCnt_r == SOFT_W'(SOFT_CYCLES - 1));

  always_comb begin
    state_nxt = state_r;
    softCnt_nxt = softCnt_r;
    detCnt_nxt = detCnt_r;
    unused_nxt = unused_r;
    fbMin_nxt = fbMin_r;
    pulseSeen_nxt = pulseSeen_r;
    case (state_r)
      LDMS_SHUTDOWN: begin
        detCnt_nxt = '0;
        // [RULE_03] Detection first on enable.
        if (enS) begin
          state_nxt = LDMS_DETECT;
        end
      end
      LDMS_DETECT: begin
        detCnt_nxt = detCnt_r + DET_W'(1);
        // [RULE_03] Latch grounded pins.
        if (detCnt_r == DET_W'(DETECT_CYCLES - 1)) begin
          unused_nxt = groundedS;
          softCnt_nxt = '0;
          state_nxt = LDMS_SOFTSTART;
        end
      end
      LDMS_SOFTSTART: begin
        // [RULE_06] Bounded soft start.
        softCnt_nxt = softCnt_r + SOFT_W'(1);
        // [RULE_08] Exit to stand-by one.
        if (softDone) begin
          state_nxt = dimS ? LDMS_OPERATE : LDMS_STANDBY1;
        end
      end
      default: begin
        if (dimFall) begin
          pulseSeen_nxt = 1'b1;
        end
        // [RULE_13] Six clocks to resume.
        if (dimS && !fbMin_r && onCount_r >= RESUME_CLKS) begin
          fbMin_nxt = 1'b1;
        end else if (dimFall && fbMin_r && onCount_r < SHORT_CLKS) begin
          fbMin_nxt = 1'b0;
        end
        // [RULE_09] Stand-by two or three.
        if (dimS) begin
          state_nxt = LDMS_OPERATE;
        end else if (!(pulseSeen_r || dimFall)) begin
          state_nxt = LDMS_STANDBY1;
        end else if (fbMin_nxt) begin
          state_nxt = LDMS_STANDBY3;
        end else begin
          state_nxt = LDMS_STANDBY2;
        end
      end
    endcase
    // [RULE_01] Enable low forces shutdown.
    if (!enS) begin
      state_nxt = LDMS_SHUTDOWN;
      unused_nxt = `LDMS_UNUSED_RST;
      fbMin_nxt = 1'b0;
      pulseSeen_nxt = 1'b0;
      softCnt_nxt = '0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= LDMS_SHUTDOWN;
      softCnt_r <= '0;
      detCnt_r <= '0;
      unused_r <= `LDMS_UNUSED_RST;
      fbMin_r <= 1'b0;
      pulseSeen_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      softCnt_r <= softCnt_nxt;
      detCnt_r <= detCnt_nxt;
      unused_r <= unused_nxt;
      fbMin_r <= fbMin_nxt;
      pulseSeen_r <= pulseSeen_nxt;
    end
  end

  // ************************************************************
  // Mode outputs
  // ************************************************************
  logic [2:0] unusedCount;

  always_comb begin
    unusedCount = 3'h0;
    for (int i = 0; i < CHANNELS; i++) begin
      unusedCount = unusedCount + 3'(unused_r[i]);
    end
  end

  assign operatingMode = state_r;
  // [RULE_02] Boost runs in operation.
  // [RULE_10] Stand-by three stops the boost.
  assign boostEnable = (state_r == LDMS_SOFTSTART) || (state_r == LDMS_STANDBY1) ||
                       (state_r == LDMS_STANDBY2) || (state_r == LDMS_OPERATE);
  // [RULE_05] Soft start uses overvoltage sense.
  // [RULE_11] Operation regulates lowest sink.
  assign feedbackMinSink = running && fbMin_r;
  assign channelActive = ~unused_r;
  // [RULE_04] Stagger off for two unused.
  assign staggerEnable = unusedCount < 3'h2;

  ldms_sink_stagger #(
    .CHANNELS(CHANNELS)
  ) u_stagger (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .sinkRequest(state_r == LDMS_OPERATE),
    .channelActive(channelActive),
    .staggerEnable(staggerEnable),
    .sinkOn(led_sink_channel)
  );

  // ************************************************************
  // Short comparator qualification
  // ************************************************************
  // Shorts are only judged while regulating the lowest sink pin; at the 95% target the
  // sink voltages are not meaningful.
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_short
      logic [SHORT_W-1:0] cnt_r;
      logic [SHORT_W-1:0] cnt_nxt;
      logic qual_r;
      logic qual_nxt;
      always_comb begin
        cnt_nxt = '0;
        qual_nxt = 1'b0;
        // [RULE_12] Qualification delay.
        if (shortS[ch] && channelActive[ch] && state_r == LDMS_OPERATE && fbMin_r) begin
          if (cnt_r == SHORT_W'(SHORT_CYCLES)) begin
            cnt_nxt = cnt_r;
            qual_nxt = 1'b1;
          end else begin
            cnt_nxt = cnt_r + SHORT_W'(1);
          end
        end
      end
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          cnt_r <= '0;
          qual_r <= 1'b0;
        end else begin
          cnt_r <= cnt_nxt;
          qual_r <= qual_nxt;
        end
      end
      assign shortQualified[ch] = qual_r;
    end
  endgenerate

  // ************************************************************
  // Checks
  // ************************************************************
  a_shutdown_hold: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_01]
    !enS |=> (state_r == LDMS_SHUTDOWN && !boostEnable && led_sink_channel == '0))
    else $error("Enable low did not hold shutdown.");

  a_operate_runs: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_02]
    (state_r == LDMS_OPERATE) |-> (boostEnable && dimPrev_r))
    else $error("Operation without boost or dimming.");

  a_detect_first: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_03]
    (state_r == LDMS_SHUTDOWN && enS) |=> (state_r == LDMS_DETECT || !$past(enS)))
    else $error("Enable rise skipped unused detection.");

  a_unused_off: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_03]
    (led_sink_channel & unused_r) == '0)
    else $error("Unused channel was driven.");

  a_stagger_off: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_04]
    (unusedCount >= 3'h2) |-> !staggerEnable)
    else $error("Stagger left on with two unused channels.");

  a_soft_target: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_05]
    (state_r == LDMS_SOFTSTART) |-> (boostEnable && !feedbackMinSink))
    else $error("Soft start not on overvoltage target.");

  a_soft_bound: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_06]
    (state_r == LDMS_SOFTSTART) |-> (softCnt_r < SOFT_W'(SOFT_CYCLES)))
    else $error("Soft start overran its limit.");

  a_soft_exit: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_07]
    (state_r == LDMS_SOFTSTART && enS && senseS && !dimS) |=> (state_r == LDMS_STANDBY1))
    else $error("Soft start did not end on overvoltage target.");

  a_standby_two: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_09]
    (state_r == LDMS_STANDBY2) |-> (boostEnable && !feedbackMinSink && led_sink_channel == '0))
    else $error("Stand-by two outputs wrong.");

  a_standby_three: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_10]
    (state_r == LDMS_STANDBY3) |-> (!boostEnable && fbMin_r))
    else $error("Stand-by three left the boost running.");

  a_resume_six: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_13]
    (running && $rose(fbMin_r)) |-> ($past(onCount_r) >= RESUME_CLKS))
    else $error("Sink regulation resumed before six clocks.");

  a_short_qual: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_12]
    $rose(shortQualified[1]) |-> $past(g_short[1].cnt_r) == SHORT_W'(SHORT_CYCLES))
    else $error("Short qualified before its delay.");

endmodule : ldms_mode_sequencer

// >>> ldms_pkg.sv
package ldms_pkg;

  // ************************************************************
  // Operating modes
  // ************************************************************
  typedef enum logic [2:0] {
    LDMS_SHUTDOWN,
    LDMS_DETECT,
    LDMS_SOFTSTART,
    LDMS_STANDBY1,
    LDMS_STANDBY2,
    LDMS_STANDBY3,
    LDMS_OPERATE
  } ldms_mode_t;

endpackage : ldms_pkg

// >>> ldms_sink_stagger.sv
`timescale 1ns/10ps
`include "ldms_consts.svh"

module ldms_sink_stagger
  import ldms_pkg::*;
#(
  parameter int CHANNELS = `LDMS_CHANNELS,
  parameter int STEP_CYCLES = (`LDMS_STAGGER_NS + `LDMS_CLK_NS - 1) / `LDMS_CLK_NS
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic sinkRequest,
  input wire logic [CHANNELS-1:0] channelActive,
  input wire logic staggerEnable,
  output logic [CHANNELS-1:0] sinkOn
);

  // ************************************************************
  // Per-channel turn-on chain
  // ************************************************************
  // Each channel passes its start token on; an inactive channel forwards it at once,
  // so only operating channels add a step of delay.
  logic [CHANNELS:0] token;
  assign token[0] = sinkRequest;

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
      logic [STEP_CYCLES-1:0] dly_r;
      logic [STEP_CYCLES-1:0] dly_nxt;
      logic ready;
      always_comb begin
        dly_nxt = STEP_CYCLES'({dly_r, token[ch]});
        if (!sinkRequest) begin
          dly_nxt = '0;
        end
      end
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          dly_r <= '0;
        end else begin
          dly_r <= dly_nxt;
        end
      end
      // [RULE_14] Step delay per channel.
      assign ready = staggerEnable ? dly_r[STEP_CYCLES-1] : token[ch];
      assign sinkOn[ch] = sinkRequest && channelActive[ch] && ready;
      assign token[ch+1] = channelActive[ch] ? sinkOn[ch] : token[ch];
    end
  endgenerate

  a_stagger_step: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_14]
    (staggerEnable && (&channelActive[2:1]) && $rose(sinkOn[2])) |-> $past(sinkOn[1]))
    else $error("Third channel turned on without a step after the second.");

endmodule : ldms_sink_stagger

// >>> tb_top.sv
`timescale 1ns/10ps

module tb_top
  import ldms_pkg::*;
;
  localparam int SOFT = 50;
  localparam int DET = 4;
  localparam int SHORT = 65;
  localparam int OSCP = 8;

  logic sys_clk, sys_rst, enReq, dimLevel, pulseStart, boostAtSenseTarget, minSinkAtTarget;
  logic [3:0] pulseCount, sinkPinGrounded, shortCompRaw;
  logic chipEnable, dimming_pwm_input, switchOscClock, pulseBusy;
  ldms_mode_t operatingMode;
  logic boostEnable, feedbackMinSink, staggerEnable;
  logic [3:0] channelActive, led_sink_channel, shortQualified;
  int nFail = 0;
  int testsRun = 0;
  int seed = 6;

  ldms_ext_ctrl #(.OSC_HALF(OSCP / 2)) i_ldms_ext_ctrl (.sys_clk(sys_clk), .enReq(enReq),
    .dimLevel(dimLevel), .pulseCount(pulseCount), .pulseStart(pulseStart),
    .chipEnable(chipEnable), .dimming_pwm_input(dimming_pwm_input),
    .switchOscClock(switchOscClock), .pulseBusy(pulseBusy));

  ldms_mode_sequencer #(.SOFT_CYCLES(SOFT), .DETECT_CYCLES(DET), .SHORT_CYCLES(SHORT))
    i_ldms_mode_sequencer (.sys_clk(sys_clk), .sys_rst(sys_rst), .chipEnable(chipEnable),
    .dimming_pwm_input(dimming_pwm_input), .switchOscClock(switchOscClock),
    .sinkPinGrounded(sinkPinGrounded), .boostAtSenseTarget(boostAtSenseTarget),
    .minSinkAtTarget(minSinkAtTarget), .shortCompRaw(shortCompRaw),
    .operatingMode(operatingMode), .boostEnable(boostEnable),
    .feedbackMinSink(feedbackMinSink), .channelActive(channelActive),
    .staggerEnable(staggerEnable), .led_sink_channel(led_sink_channel),
    .shortQualified(shortQualified));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ************************************************************
  // Checking and closing
  // ************************************************************
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nFail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stopTest();
    $display("checks %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stopTest

  function automatic logic expStagger(input logic [3:0] gnd);
    return ($countones(gnd) < 2);
  endfunction : expStagger

  function automatic logic expFb(input logic prev, input int len);
    if (len >= 6) return 1'b1;
    if (len < 5) return 1'b0;
    return prev;
  endfunction : expFb

  // ************************************************************
  // Bounded waits and pin sequences
  // ************************************************************
  task automatic waitMode(input ldms_mode_t m, input int bound, output int n);
    n = 0;
    while (operatingMode !== m) begin
      @(negedge sys_clk);
      n++;
      if (n > bound) begin
        nFail++;
        $display("mismatch mode expected %0d seen %0d", m, operatingMode);
        stopTest();
      end
    end
  endtask : waitMode

  task automatic startUp(input logic [3:0] gnd);
    int n;
    enReq = 1'b0;
    dimLevel = 1'b1;
    repeat (6) @(negedge sys_clk);
    check("shutdown mode", operatingMode, LDMS_SHUTDOWN);
    check("shutdown boost", boostEnable, 1'b0);
    check("shutdown sinks", led_sink_channel, 4'h0);
    dimLevel = 1'b0;
    repeat (4) @(negedge sys_clk);
    sinkPinGrounded = gnd;
    enReq = 1'b1;
    waitMode(LDMS_SOFTSTART, DET + 8, n);
    check("active mask", channelActive, 4'(~gnd));
    check("stagger", staggerEnable, expStagger(gnd));
    check("soft boost", boostEnable, 1'b1);
    check("soft feedback", feedbackMinSink, 1'b0);
  endtask : startUp

  // Kind 3 raises the sink comparator without dimming, which must not end soft start.
  task automatic softExit(input int kind);
    int n;
    boostAtSenseTarget = (kind == 1);
    minSinkAtTarget = (kind >= 2);
    dimLevel = (kind == 2);
    waitMode((kind == 2) ? LDMS_OPERATE : LDMS_STANDBY1, SOFT + 5, n);
    if (kind == 0 || kind == 3) begin
      check("soft length", (n >= SOFT - 3 && n <= SOFT + 3), 1'b1);
    end else begin
      check("soft early end", (n < 8), 1'b1);
    end
    check("exit feedback", feedbackMinSink, 1'b0);
    check("exit boost", boostEnable, 1'b1);
    boostAtSenseTarget = 1'b0;
    minSinkAtTarget = 1'b0;
  endtask : softExit

  task automatic operateRun();
    logic [3:0] act, first, shortMask;
    act = channelActive;
    first = 4'h0;
    repeat (8) begin
      @(negedge sys_clk);
      if (first == 4'h0) first = led_sink_channel;
    end
    check("first sinks", first, staggerEnable ? (act & (~act + 4'h1)) : act);
    check("all sinks", led_sink_channel, act);
    check("operate boost", boostEnable, 1'b1);
    repeat (OSCP * 9) @(negedge sys_clk);
    check("operate feedback", feedbackMinSink, 1'b1);
    shortMask = (4'($random(seed)) | 4'h2) & act;
    shortCompRaw = shortMask;
    repeat (SHORT - 2) @(negedge sys_clk);
    check("short early", shortQualified, 4'h0);
    repeat (8) @(negedge sys_clk);
    check("short set", shortQualified, shortMask);
    shortCompRaw = 4'h0;
    repeat (4) @(negedge sys_clk);
    check("short clear", shortQualified, 4'h0);
  endtask : operateRun

  task automatic pulse(input int len);
    int n;
    pulseCount = 4'(len);
    pulseStart = 1'b1;
    n = 0;
    while (pulseBusy !== 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 40) n = 200;
    pulseStart = 1'b0;
    while (pulseBusy === 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 200) begin
      nFail++;
      $display("mismatch pulse end expected 0 seen %b", pulseBusy);
      stopTest();
    end
    repeat (6) @(negedge sys_clk);
  endtask : pulse

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    int n, len;
    logic fb;
    logic [3:0] corner [4];
    int lens [8];
    corner = '{4'h0, 4'h1, 4'h3, 4'hF};
    lens = '{3, 6, 5, 4, 5, 7, 2, 6};
    sys_rst = 1'b1;
    enReq = 1'b0;
    dimLevel = 1'b0;
    pulseStart = 1'b0;
    pulseCount = 4'h1;
    boostAtSenseTarget = 1'b0;
    minSinkAtTarget = 1'b0;
    sinkPinGrounded = 4'h0;
    shortCompRaw = 4'h0;
    repeat (10) @(negedge sys_clk);
    check("reset mode", operatingMode, LDMS_SHUTDOWN);
    check("reset mask", channelActive, 4'hF);
    sys_rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      startUp((i < 4) ? corner[i] : 4'($random(seed)));
      softExit(i % 4);
    end
    startUp(4'h1);
    softExit(2);
    operateRun();
    dimLevel = 1'b0;
    fb = 1'b1;
    waitMode(LDMS_STANDBY3, 6, n);
    check("long standby boost", boostEnable, 1'b0);
    for (int i = 0; i < 14; i++) begin
      len = (i < 8) ? lens[i] : 1 + ($unsigned($random(seed)) % 7);
      pulse(len);
      fb = expFb(fb, len);
      check("pulse feedback", feedbackMinSink, fb);
      check("pulse mode", operatingMode, fb ? LDMS_STANDBY3 : LDMS_STANDBY2);
      check("pulse boost", boostEnable, !fb);
      check("pulse sinks", led_sink_channel, 4'h0);
    end
    dimLevel = 1'b1;
    waitMode(LDMS_OPERATE, 5, n);
    enReq = 1'b0;
    repeat (5) @(negedge sys_clk);
    check("halt mode", operatingMode, LDMS_SHUTDOWN);
    check("halt sinks", led_sink_channel, 4'h0);
    check("halt boost", boostEnable, 1'b0);
    stopTest();
  end
endmodule : tb_top
